// >>> design/flash_proto_pkg.sv
`default_nettype none
package flash_proto_pkg;
  localparam int unsigned SYS_CLK_HZ   = 100_000_000;
  localparam int unsigned SLOW_BPS     = 9_600;
  localparam int unsigned FAST_BPS     = 115_200;
  localparam int unsigned SLOW_DIV_CYC = SYS_CLK_HZ / SLOW_BPS;
  localparam int unsigned FAST_DIV_CYC = SYS_CLK_HZ / FAST_BPS;
  // frame bytes
  localparam logic [7:0] CMD_HDR   = 8'h01;
  localparam logic [7:0] DAT_HDR   = 8'h02;
  localparam logic [7:0] FOOT_LAST = 8'h03;
  localparam logic [7:0] FOOT_MORE = 8'h17;
  localparam logic [7:0] LEN_ZERO  = 8'h00;
  localparam logic [8:0] LEN_MAX   = 9'h100;
  localparam logic [7:0] SUM_INIT  = 8'h00;
  localparam logic [8:0] LEN_SIMPLE      = 9'h001;
  localparam logic [8:0] LEN_OSC         = 9'h005;
  localparam logic [8:0] LEN_BLOCK_ERASE = 9'h007;
  localparam logic [7:0] RESP_LEN_ST     = 8'h01;
  localparam logic [7:0] RESP_LEN_INFO   = 8'h02;
  localparam logic [7:0] INFO_RESET      = 8'h00;
  // command codes
  localparam logic [7:0] COM_STATUS      = 8'h70;
  localparam logic [7:0] COM_RESET       = 8'h00;
  localparam logic [7:0] COM_OSC         = 8'h90;
  localparam logic [7:0] COM_CHIP_ERASE  = 8'h20;
  localparam logic [7:0] COM_BLOCK_ERASE = 8'h22;
  localparam logic [7:0] COM_PROGRAM     = 8'h40;
  localparam logic [7:0] COM_VERIFY      = 8'h13;
  localparam logic [7:0] COM_BLANK       = 8'h32;
  localparam logic [7:0] COM_SECURITY    = 8'ha0;
  localparam logic [7:0] COM_VERSION     = 8'hc5;
  localparam logic [7:0] COM_CHECKSUM    = 8'hb0;
  // status codes
  localparam logic [7:0] ST_CMD_ERR     = 8'h04;
  localparam logic [7:0] ST_PARAM_ERR   = 8'h05;
  localparam logic [7:0] ST_ACK         = 8'h06;
  localparam logic [7:0] ST_SUM_ERR     = 8'h07;
  localparam logic [7:0] ST_PROTECT_ERR = 8'h10;
  localparam logic [7:0] ST_NACK        = 8'h15;
  localparam logic [7:0] ST_BUSY        = 8'hff;
endpackage : flash_proto_pkg
`default_nettype wire

// >>> design/serial_byte_rx.sv
`timescale 1ns/1ps
`default_nettype none
module serial_byte_rx (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        rxd,
  input  wire logic [15:0] div,
  output logic      [7:0]  byte_r,
  output logic             stb_r
);
  logic [1:0]  rxd_s;
  logic        busy_r;
  logic [15:0] cnt_r;
  logic [3:0]  bit_r;
  logic [7:0]  sh_r;

  always_ff @(posedge ref_clk) begin
    if (srst) rxd_s <= 2'b11;
    else rxd_s <= {rxd_s[0], rxd};
  end

  // 8 data bits lsb first, 1 stop bit, no parity
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busy_r <= 1'b0;
      cnt_r  <= 16'h0000;
      bit_r  <= 4'h0;
      sh_r   <= 8'h00;
      byte_r <= 8'h00;
      stb_r  <= 1'b0;
    end else begin
      stb_r <= 1'b0;
      if (!busy_r) begin
        if (!rxd_s[1]) begin
          busy_r <= 1'b1;
          cnt_r  <= {1'b0, div[15:1]};
          bit_r  <= 4'h0;
        end
      end else if (cnt_r != 16'h0000) begin
        cnt_r <= cnt_r - 16'h0001;
      end else begin
        cnt_r <= div - 16'h0001;
        bit_r <= bit_r + 4'h1;
        if (bit_r == 4'h0 && rxd_s[1]) begin
          busy_r <= 1'b0;
        end else if (bit_r == 4'h9) begin
          busy_r <= 1'b0;
          byte_r <= sh_r;
          stb_r  <= rxd_s[1];
        end else if (bit_r != 4'h0) begin
          sh_r <= {rxd_s[1], sh_r[7:1]};
        end
      end
    end
  end
endmodule : serial_byte_rx
`default_nettype wire

// >>> design/serial_byte_tx.sv
`timescale 1ns/1ps
`default_nettype none
module serial_byte_tx (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [15:0] div,
  input  wire logic [7:0]  data,
  input  wire logic        req,
  output logic             rdy,
  output logic             txd_r
);
  logic [9:0]  sh_r;
  logic [3:0]  left_r;
  logic [15:0] cnt_r;

  assign rdy = (left_r == 4'h0);

  // start, 8 bits lsb first, stop; one spare slot keeps the stop bit whole
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sh_r   <= 10'h3ff;
      left_r <= 4'h0;
      cnt_r  <= 16'h0000;
      txd_r  <= 1'b1;
    end else if (req && rdy) begin
      sh_r   <= {1'b1, data, 1'b0};
      left_r <= 4'hb;
      cnt_r  <= 16'h0000;
    end else if (left_r != 4'h0) begin
      if (cnt_r == 16'h0000) begin
        txd_r  <= sh_r[0];
        sh_r   <= {1'b1, sh_r[9:1]};
        left_r <= left_r - 4'h1;
        cnt_r  <= div - 16'h0001;
      end else begin
        cnt_r <= cnt_r - 16'h0001;
      end
    end
  end
endmodule : serial_byte_tx
`default_nettype wire

// >>> design/flash_cmd_target.sv
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_target #(
  parameter int unsigned SLOW_DIV = flash_proto_pkg::SLOW_DIV_CYC,
  parameter int unsigned FAST_DIV = flash_proto_pkg::FAST_DIV_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       csi_sel,
  input  wire logic       rxd,
  output logic            txd,
  input  wire logic       serial_clk,
  input  wire logic       serial_in,
  output logic            serial_out_r,
  output logic            exec_start_r,
  output logic [7:0]      exec_code_r,
  output logic [7:0]      param_byte_r,
  output logic            param_valid_r,
  input  wire logic       exec_done,
  input  wire logic [7:0] exec_status,
  input  wire logic [7:0] exec_info,
  output logic            secure_r,
  output logic            fast_r
);
  import flash_proto_pkg::*;

  typedef enum logic [2:0] {P_HDR, P_LEN, P_BODY, P_SUM, P_FOOT} parse_type;
  typedef enum logic [1:0] {E_IDLE, E_DATA, E_RUN} exec_type;
  typedef enum logic [2:0] {T_IDLE, T_HDR, T_LEN, T_ST, T_INFO, T_SUM, T_FOOT} tx_type;

  if (SLOW_DIV < 4 || FAST_DIV < 4 || SLOW_DIV > 65535 || FAST_DIV > 65535) begin : g_bad
    $error("baud divisor out of range");
  end

  function automatic logic known_com(input logic [7:0] c);
    case (c)
      COM_STATUS, COM_RESET, COM_OSC:               known_com = 1'b1;
      COM_CHIP_ERASE, COM_BLOCK_ERASE, COM_PROGRAM: known_com = 1'b1;
      COM_VERIFY, COM_BLANK, COM_SECURITY:          known_com = 1'b1;
      COM_VERSION, COM_CHECKSUM:                    known_com = 1'b1;
      default:                                      known_com = 1'b0;
    endcase
  endfunction : known_com

  function automatic logic [8:0] fixed_len(input logic [7:0] c);
    case (c)
      COM_STATUS, COM_RESET, COM_CHIP_ERASE: fixed_len = LEN_SIMPLE;
      COM_OSC:                               fixed_len = LEN_OSC;
      COM_BLOCK_ERASE:                       fixed_len = LEN_BLOCK_ERASE;
      default:                               fixed_len = 9'h000;
    endcase
  endfunction : fixed_len

  function automatic logic needs_data(input logic [7:0] c);
    needs_data = (c == COM_PROGRAM) || (c == COM_VERIFY) || (c == COM_SECURITY);
  endfunction : needs_data

  logic [1:0]  sck_s;
  logic [1:0]  si_s;
  logic [1:0]  sel_s;
  logic        sck_prev_r;
  logic        csi_m;
  logic        sck_rise;
  logic        sck_fall;
  logic [7:0]  csi_rsh_r;
  logic [7:0]  csi_tsh_r;
  logic [7:0]  csi_byte_r;
  logic [2:0]  csi_cnt_r;
  logic        csi_stb_r;
  logic        csi_take;
  logic [15:0] div;
  logic [7:0]  uart_byte;
  logic        uart_stb;
  logic        uart_rdy;
  logic [7:0]  rx_byte;
  logic        rx_stb;
  logic        tx_req;
  logic        tx_take;
  logic [7:0]  tx_byte;
  logic [7:0]  tx_len;
  parse_type   p_state_r;
  logic        is_cmd_r;
  logic        first_r;
  logic [8:0]  len_r;
  logic [8:0]  remain_r;
  logic [7:0]  sum_r;
  logic        sum_ok_r;
  logic [7:0]  com_r;
  logic        foot_ok;
  logic        frame_fire;
  exec_type    e_state_r;
  logic [7:0]  last_st_r;
  logic [7:0]  info_r;
  logic        two_r;
  logic        reply_go_r;
  logic        res_set;
  logic [7:0]  res_val;
  logic        res_two;
  logic        go_exec;
  logic        go_data;
  logic        go_idle;
  logic        csi_query;
  logic        osc_ok;
  logic        done_ok;
  logic        fast_pend_r;
  tx_type      t_state_r;
  logic [7:0]  tsum_r;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  // pin synchronisers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sck_s      <= 2'b11;
      si_s       <= 2'b00;
      sel_s      <= 2'b00;
      sck_prev_r <= 1'b1;
    end else begin
      sck_s      <= {sck_s[0], serial_clk};
      si_s       <= {si_s[0], serial_in};
      sel_s      <= {sel_s[0], csi_sel};
      sck_prev_r <= sck_s[1];
    end
  end

  assign csi_m    = sel_s[1];
  assign sck_rise = sck_s[1] & ~sck_prev_r;
  assign sck_fall = ~sck_s[1] & sck_prev_r;
  assign csi_take = csi_m & sck_rise & (csi_cnt_r == 3'h7);

  // three-wire receive, sampled on rising clock
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      csi_rsh_r  <= 8'h00;
      csi_byte_r <= 8'h00;
      csi_cnt_r  <= 3'h0;
      csi_stb_r  <= 1'b0;
    end else begin
      csi_stb_r <= csi_take;
      if (csi_m && sck_rise) begin
        csi_rsh_r <= {csi_rsh_r[6:0], si_s[1]};
        csi_cnt_r <= csi_cnt_r + 3'h1;
        if (csi_cnt_r == 3'h7) csi_byte_r <= {csi_rsh_r[6:0], si_s[1]};
      end
    end
  end

  // three-wire transmit, shifted on falling clock; idle slots carry busy
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      csi_tsh_r    <= ST_BUSY;
      serial_out_r <= 1'b1;
    end else begin
      if (csi_take) csi_tsh_r <= tx_req ? tx_byte : ST_BUSY;
      else if (csi_m && sck_fall && csi_cnt_r != 3'h0) csi_tsh_r <= {csi_tsh_r[6:0], 1'b0};
      serial_out_r <= csi_tsh_r[7];
    end
  end

  assign div = fast_r ? 16'(FAST_DIV) : 16'(SLOW_DIV);

  serial_byte_rx u_rx (
    .ref_clk (ref_clk),
    .srst    (srst),
    .rxd     (rxd),
    .div     (div),
    .byte_r  (uart_byte),
    .stb_r   (uart_stb)
  );

  serial_byte_tx u_tx (
    .ref_clk (ref_clk),
    .srst    (srst),
    .div     (div),
    .data    (tx_byte),
    .req     (tx_req & ~csi_m),
    .rdy     (uart_rdy),
    .txd_r   (txd)
  );

  assign rx_byte = csi_m ? csi_byte_r : uart_byte;
  assign rx_stb  = csi_m ? csi_stb_r : uart_stb;
  assign tx_take = tx_req & (csi_m ? csi_take : uart_rdy);

  // frame parser
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      p_state_r     <= P_HDR;
      is_cmd_r      <= 1'b0;
      first_r       <= 1'b0;
      len_r         <= LEN_MAX;
      remain_r      <= LEN_MAX;
      sum_r         <= SUM_INIT;
      sum_ok_r      <= 1'b0;
      com_r         <= COM_RESET;
      param_byte_r  <= INFO_RESET;
      param_valid_r <= 1'b0;
    end else begin
      param_valid_r <= 1'b0;
      if (rx_stb) begin
        case (p_state_r)
          P_HDR: begin
            if (rx_byte == CMD_HDR || rx_byte == DAT_HDR) p_state_r <= P_LEN;
            is_cmd_r <= (rx_byte == CMD_HDR);
          end
          P_LEN: begin
            len_r     <= (rx_byte == LEN_ZERO) ? LEN_MAX : {1'b0, rx_byte};
            remain_r  <= (rx_byte == LEN_ZERO) ? LEN_MAX : {1'b0, rx_byte};
            sum_r     <= SUM_INIT - rx_byte;
            first_r   <= is_cmd_r;
            p_state_r <= P_BODY;
          end
          P_BODY: begin
            sum_r    <= sum_r - rx_byte;
            remain_r <= remain_r - 9'h001;
            if (first_r) begin
              com_r   <= rx_byte;
              first_r <= 1'b0;
            end else begin
              param_byte_r  <= rx_byte;
              param_valid_r <= 1'b1;
            end
            if (remain_r == 9'h001) p_state_r <= P_SUM;
          end
          P_SUM: begin
            sum_ok_r  <= (sum_r == rx_byte);
            p_state_r <= P_FOOT;
          end
          P_FOOT: p_state_r <= P_HDR;
          default: p_state_r <= P_HDR;
        endcase
      end
    end
  end

  assign foot_ok = is_cmd_r ? (rx_byte == FOOT_LAST) :
                   (rx_byte == FOOT_LAST || rx_byte == FOOT_MORE);
  assign frame_fire = rx_stb && p_state_r == P_FOOT && foot_ok;
  assign done_ok = exec_done && e_state_r == E_RUN && exec_status == ST_ACK;

  // command decode and result selection
  always_comb begin
    res_set   = 1'b0;
    res_val   = ST_ACK;
    res_two   = 1'b0;
    go_exec   = 1'b0;
    go_data   = 1'b0;
    go_idle   = 1'b0;
    csi_query = 1'b0;
    osc_ok    = 1'b0;
    if (frame_fire) begin
      if (!sum_ok_r) begin
        res_set = 1'b1;
        res_val = ST_SUM_ERR;
        go_idle = 1'b1;
      end else if (is_cmd_r) begin
        if (com_r == COM_STATUS && csi_m) begin
          csi_query = 1'b1;
        end else if (e_state_r != E_RUN) begin
          res_set = 1'b1;
          if (!known_com(com_r) || com_r == COM_STATUS) begin
            res_val = ST_CMD_ERR;
          end else if (fixed_len(com_r) != 9'h000 && len_r != fixed_len(com_r)) begin
            res_val = ST_PARAM_ERR;
          end else if (secure_r && (com_r == COM_BLOCK_ERASE || com_r == COM_PROGRAM)) begin
            res_val = ST_PROTECT_ERR;
          end else if (needs_data(com_r)) begin
            go_data = 1'b1;
          end else if (com_r == COM_OSC) begin
            osc_ok = 1'b1;
          end else if (com_r != COM_RESET) begin
            res_set = 1'b0;
            go_exec = 1'b1;
          end
        end
      end else if (e_state_r == E_DATA) begin
        if (rx_byte == FOOT_LAST) go_exec = 1'b1;
        else res_set = 1'b1;
      end else if (e_state_r == E_IDLE) begin
        res_set = 1'b1;
        res_val = ST_NACK;
      end
    end else if (exec_done && e_state_r == E_RUN) begin
      res_set = 1'b1;
      res_val = exec_status;
      res_two = done_ok && (exec_code_r == COM_VERSION || exec_code_r == COM_CHECKSUM);
      go_idle = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      e_state_r    <= E_IDLE;
      last_st_r    <= ST_ACK;
      info_r       <= INFO_RESET;
      two_r        <= 1'b0;
      reply_go_r   <= 1'b0;
      exec_start_r <= 1'b0;
      exec_code_r  <= COM_RESET;
    end else begin
      exec_start_r <= go_exec;
      reply_go_r   <= (res_set & ~csi_m) | csi_query;
      if (res_set) begin
        last_st_r <= res_val;
        two_r     <= res_two;
        info_r    <= exec_info;
      end else if (go_exec) begin
        last_st_r <= ST_BUSY;
      end
      if (go_exec && is_cmd_r) exec_code_r <= com_r;
      if (go_data) begin
        exec_code_r <= com_r;
        e_state_r   <= E_DATA;
      end else if (go_exec) begin
        e_state_r <= E_RUN;
      end else if (go_idle) begin
        e_state_r <= E_IDLE;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) secure_r <= 1'b0;
    else if (done_ok && exec_code_r == COM_CHIP_ERASE) secure_r <= 1'b0;
    else if (done_ok && exec_code_r == COM_SECURITY) secure_r <= 1'b1;
  end

  // reply framer
  assign tx_req = (t_state_r != T_IDLE);
  assign tx_len = two_r ? RESP_LEN_INFO : RESP_LEN_ST;

  always_comb begin
    case (t_state_r)
      T_HDR:   tx_byte = DAT_HDR;
      T_LEN:   tx_byte = tx_len;
      T_ST:    tx_byte = last_st_r;
      T_INFO:  tx_byte = info_r;
      T_SUM:   tx_byte = tsum_r;
      T_FOOT:  tx_byte = FOOT_LAST;
      default: tx_byte = ST_BUSY;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      t_state_r <= T_IDLE;
      tsum_r    <= SUM_INIT;
    end else begin
      case (t_state_r)
        T_IDLE: if (reply_go_r) t_state_r <= T_HDR;
        T_HDR: if (tx_take) begin
          tsum_r    <= SUM_INIT;
          t_state_r <= T_LEN;
        end
        T_LEN: if (tx_take) begin
          tsum_r    <= tsum_r - tx_byte;
          t_state_r <= T_ST;
        end
        T_ST: if (tx_take) begin
          tsum_r    <= tsum_r - tx_byte;
          t_state_r <= two_r ? T_INFO : T_SUM;
        end
        T_INFO: if (tx_take) begin
          tsum_r    <= tsum_r - tx_byte;
          t_state_r <= T_SUM;
        end
        T_SUM: if (tx_take) t_state_r <= T_FOOT;
        T_FOOT: if (tx_take) t_state_r <= T_IDLE;
        default: t_state_r <= T_IDLE;
      endcase
    end
  end

  // rate switch once the oscillator reply has fully left the line
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fast_pend_r <= 1'b0;
      fast_r      <= 1'b0;
    end else if (osc_ok && !csi_m) begin
      fast_pend_r <= 1'b1;
    end else if (fast_pend_r && t_state_r == T_IDLE && !reply_go_r && uart_rdy) begin
      fast_pend_r <= 1'b0;
      fast_r      <= 1'b1;
    end
  end

  sequence good_cmd_s;
    frame_fire && sum_ok_r && is_cmd_r && e_state_r != E_RUN;
  endsequence

  sequence uart_reply_s;
    reply_go_r ##1 (t_state_r == T_HDR);
  endsequence

  len_zero_a: assert property (
    rx_stb && p_state_r == P_LEN && rx_byte == LEN_ZERO |=> len_r == LEN_MAX && p_state_r == P_BODY
  ) else $error("zero length not taken as 256");

  sum_err_a: assert property (
    frame_fire && !sum_ok_r |=> last_st_r == ST_SUM_ERR && !exec_start_r
  ) else $error("checksum mismatch not reported");

  tx_sum_a: assert property (
    tx_take && t_state_r == T_SUM |->
      tx_byte == 8'(SUM_INIT - tx_len - last_st_r - (two_r ? info_r : SUM_INIT))
  ) else $error("reply checksum wrong");

  tx_head_a: assert property (
    tx_take && t_state_r == T_HDR |-> tx_byte == DAT_HDR ##1 t_state_r == T_LEN
  ) else $error("reply header wrong");

  tx_foot_a: assert property (
    tx_take && t_state_r == T_FOOT |-> tx_byte == FOOT_LAST ##1 t_state_r == T_IDLE
  ) else $error("reply footer wrong");

  bad_foot_a: assert property (
    rx_stb && p_state_r == P_FOOT && !foot_ok |=> !exec_start_r && !reply_go_r
  ) else $error("frame with bad footer acted on");

  uart_status_a: assert property (
    good_cmd_s ##0 (com_r == COM_STATUS && !csi_m) |=> last_st_r == ST_CMD_ERR ##0 uart_reply_s
  ) else $error("uart status query not refused");

  unknown_cmd_a: assert property (
    good_cmd_s ##0 !known_com(com_r) |=> last_st_r == ST_CMD_ERR && !exec_start_r
  ) else $error("unknown code not reported");

  erase_secure_a: assert property (
    done_ok && exec_code_r == COM_CHIP_ERASE |=> !secure_r
  ) else $error("erase left security flag set");

  protect_a: assert property (
    good_cmd_s ##0 (secure_r && com_r == COM_PROGRAM) |=> last_st_r == ST_PROTECT_ERR ##1 !exec_start_r
  ) else $error("protected program not refused");

  csi_busy_a: assert property (
    csi_take && !tx_req |=> csi_tsh_r == ST_BUSY
  ) else $error("idle three-wire slot not busy");

  run_busy_a: assert property (
    exec_start_r |-> last_st_r == ST_BUSY && e_state_r == E_RUN
  ) else $error("busy status missing while running");
endmodule : flash_cmd_target
`default_nettype wire

// >>> tb/flash_programmer_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_programmer_model #(
  parameter int SLOW = 16,
  parameter int FAST = 8
) (
  input  wire logic ref_clk,
  input  wire logic fast,
  input  wire logic from_target,
  output logic      to_target
);
  logic [7:0] rx_q[$];
  logic [7:0] rx_b;
  initial to_target = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      to_target <= f[i];
      repeat (fast ? FAST : SLOW) @(posedge ref_clk);
    end
  endtask : send_byte
  task automatic send_frame(input logic [7:0] hdr, input logic [7:0] body[$],
                            input logic [7:0] ftr, input bit bad);
    logic [7:0] sum;
    sum = 8'h00 - 8'(body.size());
    foreach (body[i]) sum -= body[i];
    send_byte(hdr);
    send_byte(8'(body.size()));
    foreach (body[i]) send_byte(body[i]);
    send_byte(bad ? ~sum : sum);
    send_byte(ftr);
  endtask : send_frame
  // receiver runs free so no reply byte is missed
  always begin
    @(posedge ref_clk);
    if (from_target === 1'b0) begin
      repeat ((fast ? FAST : SLOW) / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (fast ? FAST : SLOW) @(posedge ref_clk);
        rx_b[i] = from_target;
      end
      repeat (fast ? FAST : SLOW) @(posedge ref_clk);
      rx_q.push_back(rx_b);
    end
  end
endmodule : flash_programmer_model
`default_nettype wire

// >>> tb/flash_programming_command_protocol_test.sv
`timescale 1ns/1ps
`default_nettype none
module flash_programming_command_protocol_test;
  import flash_proto_pkg::*;
  logic       ref_clk = 1'b0;
  logic       srst = 1'b1;
  logic       rxd;
  logic       txd;
  logic       exec_start_r;
  logic [7:0] exec_code_r;
  logic       exec_done = 1'b0;
  logic [7:0] exec_status = 8'h00;
  logic [7:0] exec_info = 8'h00;
  logic       secure_r;
  logic       fast_r;
  logic       csi_sel = 1'b0;
  logic       serial_clk = 1'b1;
  logic       serial_in = 1'b1;
  logic       serial_out_r;
  logic [7:0] par_byte;
  logic       par_valid;
  logic [7:0] last_par;
  logic [7:0] last_code;
  int         starts = 0;
  int         n_ops = 0;
  int         n_errors = 0;
  int         cmp_count = 0;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (exec_start_r === 1'b1) begin
      starts <= starts + 1;
      last_code <= exec_code_r;
    end
    if (par_valid === 1'b1) last_par <= par_byte;
  end
  flash_cmd_target #(.SLOW_DIV(16), .FAST_DIV(8)) flash_cmd_target_i (
    .ref_clk(ref_clk), .srst(srst), .csi_sel(csi_sel), .rxd(rxd), .txd(txd),
    .serial_clk(serial_clk), .serial_in(serial_in), .serial_out_r(serial_out_r),
    .exec_start_r(exec_start_r), .exec_code_r(exec_code_r),
    .param_byte_r(par_byte), .param_valid_r(par_valid), .exec_done(exec_done),
    .exec_status(exec_status), .exec_info(exec_info), .secure_r(secure_r), .fast_r(fast_r));
  flash_programmer_model #(.SLOW(16), .FAST(8)) flash_programmer_model_i (
    .ref_clk(ref_clk), .fast(fast_r), .from_target(txd), .to_target(rxd));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  task automatic get_byte(output logic [7:0] b);
    if (csi_sel) begin
      csi_xfer(8'hff, b);
      return;
    end
    for (int i = 0; i < 4000 && flash_programmer_model_i.rx_q.size() == 0; i++)
      @(posedge ref_clk);
    if (flash_programmer_model_i.rx_q.size() == 0) begin
      check("reply arrival", 8'h00, 8'h01);
      results();
    end
    b = flash_programmer_model_i.rx_q.pop_front();
  endtask : get_byte
  task automatic expect_reply(input logic [7:0] st, input bit inf, input logic [7:0] info);
    logic [7:0] b;
    logic [7:0] len;
    len = inf ? RESP_LEN_INFO : RESP_LEN_ST;
    get_byte(b);
    for (int i = 0; i < 3 && b === ST_BUSY; i++) get_byte(b);
    check("reply header", b, DAT_HDR);
    get_byte(b); check("reply length", b, len);
    get_byte(b); check("reply status", b, st);
    if (inf) begin
      get_byte(b); check("reply info", b, info);
    end
    get_byte(b); check("reply sum", b, SUM_INIT - len - st - (inf ? info : 8'h00));
    get_byte(b); check("reply footer", b, FOOT_LAST);
  endtask : expect_reply
  task automatic cmd(input logic [7:0] code, input int np, input logic [7:0] ftr, input bit bad);
    logic [7:0] q[$];
    q = {code};
    repeat (np) q.push_back(8'h00);
    @(posedge ref_clk);
    flash_programmer_model_i.send_frame(CMD_HDR, q, ftr, bad);
  endtask : cmd
  task automatic dat(input logic [7:0] ftr);
    logic [7:0] q[$];
    q = {8'h5a};
    @(posedge ref_clk);
    flash_programmer_model_i.send_frame(DAT_HDR, q, ftr, 1'b0);
  endtask : dat
  task automatic engine(input logic [7:0] code, input logic [7:0] st, input logic [7:0] info);
    for (int i = 0; i < 1000 && starts == n_ops; i++) @(posedge ref_clk);
    if (starts == n_ops) begin
      check("engine start", 8'h00, 8'h01);
      results();
    end
    n_ops++;
    check("engine code", last_code, code);
    @(posedge ref_clk);
    exec_done <= 1'b1;
    exec_status <= st;
    exec_info <= info;
    @(posedge ref_clk);
    exec_done <= 1'b0;
  endtask : engine
  task automatic t_basic();
    cmd(COM_RESET, 0, FOOT_LAST, 0);
    expect_reply(ST_ACK, 0, 8'h00);
    cmd(COM_RESET, 0, FOOT_LAST, 1);
    expect_reply(ST_SUM_ERR, 0, 8'h00);
    cmd(COM_RESET, 0, FOOT_LAST, 0);
    expect_reply(ST_ACK, 0, 8'h00);
    dat(FOOT_LAST);
    expect_reply(ST_NACK, 0, 8'h00);
    check("param byte", last_par, 8'h5a);
    cmd(8'h55, 0, FOOT_LAST, 0);
    expect_reply(ST_CMD_ERR, 0, 8'h00);
    cmd(COM_STATUS, 0, FOOT_LAST, 0);
    expect_reply(ST_CMD_ERR, 0, 8'h00);
    cmd(COM_CHIP_ERASE, 1, FOOT_LAST, 0);
    expect_reply(ST_PARAM_ERR, 0, 8'h00);
    cmd(COM_CHIP_ERASE, 0, FOOT_MORE, 0);
    repeat (400) @(posedge ref_clk);
    check("dropped reply", 8'(flash_programmer_model_i.rx_q.size()), 8'h00);
    check("dropped start", 8'(starts - n_ops), 8'h00);
    $display("basic frame test done");
  endtask : t_basic
  task automatic t_exec();
    logic [7:0] codes[5] = '{COM_CHIP_ERASE, COM_BLOCK_ERASE, COM_BLANK, COM_VERSION,
                             COM_CHECKSUM};
    logic [7:0] sts[5] = '{ST_ACK, 8'h1a, 8'h1b, ST_ACK, ST_ACK};
    int np[5] = '{0, 6, 0, 0, 0};
    foreach (codes[i]) begin
      cmd(codes[i], np[i], FOOT_LAST, 0);
      engine(codes[i], sts[i], 8'h3c);
      expect_reply(sts[i], i > 2, 8'h3c);
    end
    $display("engine command test done");
  endtask : t_exec
  task automatic t_secure();
    cmd(COM_VERIFY, 0, FOOT_LAST, 0);
    expect_reply(ST_ACK, 0, 8'h00);
    dat(FOOT_LAST);
    engine(COM_VERIFY, 8'h0f, 8'h00);
    expect_reply(8'h0f, 0, 8'h00);
    cmd(COM_SECURITY, 0, FOOT_LAST, 0);
    expect_reply(ST_ACK, 0, 8'h00);
    dat(FOOT_MORE);
    expect_reply(ST_ACK, 0, 8'h00);
    dat(FOOT_LAST);
    engine(COM_SECURITY, ST_ACK, 8'h00);
    expect_reply(ST_ACK, 0, 8'h00);
    check("secure set", {7'h00, secure_r}, 8'h01);
    cmd(COM_BLOCK_ERASE, 6, FOOT_LAST, 0);
    expect_reply(ST_PROTECT_ERR, 0, 8'h00);
    cmd(COM_PROGRAM, 0, FOOT_LAST, 0);
    expect_reply(ST_PROTECT_ERR, 0, 8'h00);
    cmd(COM_CHIP_ERASE, 0, FOOT_LAST, 0);
    engine(COM_CHIP_ERASE, ST_ACK, 8'h00);
    expect_reply(ST_ACK, 0, 8'h00);
    check("secure cleared", {7'h00, secure_r}, 8'h00);
    $display("security test done");
  endtask : t_secure
  task automatic t_osc();
    cmd(COM_OSC, 4, FOOT_LAST, 0);
    expect_reply(ST_ACK, 0, 8'h00);
    for (int i = 0; i < 200 && fast_r !== 1'b1; i++) @(posedge ref_clk);
    check("fast rate", {7'h00, fast_r}, 8'h01);
    cmd(COM_RESET, 0, FOOT_LAST, 0);
    expect_reply(ST_ACK, 0, 8'h00);
    $display("rate switch test done");
  endtask : t_osc
  // one byte slot, 40 cycles per bit keeps the clock at 2.5 MHz
  task automatic csi_xfer(input logic [7:0] o, output logic [7:0] r);
    for (int k = 7; k >= 0; k--) begin
      serial_clk <= 1'b0;
      serial_in  <= o[k];
      repeat (20) @(posedge ref_clk);
      r[k] = serial_out_r;
      serial_clk <= 1'b1;
      repeat (20) @(posedge ref_clk);
    end
  endtask : csi_xfer
  task automatic csi_cmd(input logic [7:0] code);
    logic [7:0] f[5];
    logic [7:0] b;
    f = '{CMD_HDR, 8'h01, code, 8'h00 - 8'h01 - code, FOOT_LAST};
    foreach (f[k]) begin
      csi_xfer(f[k], b);
      check("idle slot", b, ST_BUSY);
    end
  endtask : csi_cmd
  task automatic t_csi();
    repeat (40) @(posedge ref_clk);
    srst <= 1'b1;
    csi_sel <= 1'b1;
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check("fast after reset", {7'h00, fast_r}, 8'h00);
    csi_cmd(COM_CHIP_ERASE);
    csi_cmd(COM_STATUS);
    expect_reply(ST_BUSY, 0, 8'h00);
    engine(COM_CHIP_ERASE, ST_ACK, 8'h00);
    csi_cmd(COM_STATUS);
    expect_reply(ST_ACK, 0, 8'h00);
    $display("three-wire test done");
  endtask : t_csi
  initial begin
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    t_basic();
    t_exec();
    t_secure();
    t_osc();
    t_csi();
    results();
  end
endmodule : flash_programming_command_protocol_test
`default_nettype wire
